//--- logic/tsl_defs.svh
`ifndef TSL_DEFS_SVH
`define TSL_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define TSL_OFF_MODE 8'h00
`define TSL_OFF_RAMP_OFS 8'h04
`define TSL_OFF_PHASE_OFS 8'h08
`define TSL_OFF_RAMP_INC 8'h0C
`define TSL_OFF_PHASE_INC 8'h10
`define TSL_OFF_IRQ_STAT 8'h14
`define TSL_OFF_IRQ_EN 8'h18
`define TSL_OFF_IRQ_FLAG 8'h1C

// ---------------------------------------------------------------
// mode control fields
// ---------------------------------------------------------------
`define TSL_MODE_SRC_LSB 0
`define TSL_MODE_SRC_MSB 2
`define TSL_MODE_HOLD_BIT 3
`define TSL_MODE_SINE_BIT 4
`define TSL_MODE_ARM_BIT 5

// ---------------------------------------------------------------
// load-source codes
// ---------------------------------------------------------------
`define TSL_SRC_IMMED 3'h0
`define TSL_SRC_AUX_RISE 3'h1
`define TSL_SRC_SEC_RISE 3'h2
`define TSL_SRC_SEC_FALL 3'h3
`define TSL_SRC_SYNC_RISE 3'h4
`define TSL_SRC_SYNC_FALL 3'h5
`define TSL_SRC_NONE 3'h6
`define TSL_SRC_GATE_RISE 3'h7

// ---------------------------------------------------------------
// timing-event stream bits and interrupt bits
// ---------------------------------------------------------------
`define TSL_EV_AUX 0
`define TSL_EV_SEC 1
`define TSL_EV_SYNC 2
`define TSL_EV_GATE 3
`define TSL_IRQ_ARMED 0
`define TSL_IRQ_LOAD 1

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TSL_RST_MODE 6'h00
`define TSL_RST_RAMP_INC 16'h0001
`define TSL_RST_PHASE_INC 32'h00000000

`endif

//--- logic/tsl_pkg.sv
package tsl_pkg;

    // load-control machine states
    typedef enum logic [0:0] {
        TSL_WAIT_ARM,
        TSL_ARMED
    } tsl_state_e;

    typedef logic [2:0] tsl_src_t;
    typedef logic [3:0] tsl_events_t;
    typedef logic [1:0] tsl_irq_t;

endpackage : tsl_pkg

//--- logic/tsl_trig_edge.sv
`timescale 1ns/1ps
`include "tsl_defs.svh"

module tsl_trig_edge
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ev_valid_i,
    input wire tsl_pkg::tsl_events_t ev_bits_i,
    input wire tsl_pkg::tsl_src_t src_i,
    output logic trig_o
);
    import tsl_pkg::*;

    tsl_events_t rise;
    tsl_events_t fall;
    logic trig_sel;

    // ---------------------------------------------------------------
    // per-line edge detection, held level updated on valid beats only
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_edge
            // one held level per line, so each flip-flop has a single process
            logic lvl_reg;

            always_ff @(posedge core_clk_i)
            begin
                if (!rst_n_i)
                    lvl_reg <= 1'b0;
                else if (ev_valid_i)
                    lvl_reg <= ev_bits_i[g];
            end
            assign rise[g] = ev_valid_i & ev_bits_i[g] & ~lvl_reg;
            assign fall[g] = ev_valid_i & ~ev_bits_i[g] & lvl_reg;
        end
    endgenerate

    // source selection; code 110 never fires
    always_comb
    begin
        unique case (src_i)
            `TSL_SRC_IMMED: trig_sel = 1'b1; // R01
            `TSL_SRC_AUX_RISE: trig_sel = rise[`TSL_EV_AUX]; // R01
            `TSL_SRC_SEC_RISE: trig_sel = rise[`TSL_EV_SEC]; // R01
            `TSL_SRC_SEC_FALL: trig_sel = fall[`TSL_EV_SEC]; // R01
            `TSL_SRC_SYNC_RISE: trig_sel = rise[`TSL_EV_SYNC]; // R01
            `TSL_SRC_SYNC_FALL: trig_sel = fall[`TSL_EV_SYNC]; // R01
            `TSL_SRC_NONE: trig_sel = 1'b0; // R09
            `TSL_SRC_GATE_RISE: trig_sel = rise[`TSL_EV_GATE]; // R01
        endcase
    end

    assign trig_o = trig_sel;

endmodule : tsl_trig_edge

//--- logic/tsl_load_ctrl.sv
// Functional notes
// R01 - load source code picks trigger: immediate, aux, second tick, sync, gate edges
// R02 - hold-armed set keeps machine in Armed for every later trigger
// R03 - waveform select 0 outputs ramp, 1 outputs sine
// R04 - one-cycle arm bit moves machine from wait-for-arm to Armed
// R05 - Armed waits for trigger, loads both offsets, returns to wait-for-arm
// R06 - synchronous active-low reset returns machine to initial state
// R07 - rising edge of enabled source gives one-cycle interrupt pulse
// R08 - each source latched in flag bit regardless of enable, write one clears
// R09 - load source code 110 never triggers a load
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`include "tsl_defs.svh"

module tsl_load_ctrl
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // timing-event stream in
    input wire logic ev_tvalid_i,
    input wire logic [7:0] ev_tdata_i,
    // sample stream out
    output logic [15:0] smp_tdata_o,
    output logic smp_tvalid_o,
    input wire logic smp_tready_i,
    // interrupts
    output logic irq_o,
    output logic irq_pulse_o
);
    import tsl_pkg::*;

    // ---------------------------------------------------------------
    // bus slave
    // ---------------------------------------------------------------
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    wire addr_ph = hsel_i & htrans_i[1] & hready_i;
    wire wr_mode = wr_pend_reg & (wr_addr_reg == `TSL_OFF_MODE);
    wire wr_rofs = wr_pend_reg & (wr_addr_reg == `TSL_OFF_RAMP_OFS);
    wire wr_pofs = wr_pend_reg & (wr_addr_reg == `TSL_OFF_PHASE_OFS);
    wire wr_rinc = wr_pend_reg & (wr_addr_reg == `TSL_OFF_RAMP_INC);
    wire wr_pinc = wr_pend_reg & (wr_addr_reg == `TSL_OFF_PHASE_INC);
    wire wr_ien = wr_pend_reg & (wr_addr_reg == `TSL_OFF_IRQ_EN);
    wire wr_flag = wr_pend_reg & (wr_addr_reg == `TSL_OFF_IRQ_FLAG);

    // zero-wait slave, always okay
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata_reg;

    // capture write address phase
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= addr_ph & hwrite_i;
            wr_addr_reg <= haddr_i;
        end
    end

    // ---------------------------------------------------------------
    // control registers
    // ---------------------------------------------------------------
    logic [5:0] mode_reg;
    logic [15:0] ramp_ofs_reg;
    logic [31:0] phase_ofs_reg;
    logic [15:0] ramp_inc_reg;
    logic [31:0] phase_inc_reg;
    tsl_irq_t ien_reg;
    logic arm_pulse;
    wire tsl_src_t load_src = mode_reg[`TSL_MODE_SRC_MSB:`TSL_MODE_SRC_LSB];
    wire hold_armed = mode_reg[`TSL_MODE_HOLD_BIT];
    wire sel_sine = mode_reg[`TSL_MODE_SINE_BIT];

    // arm is write-only: a one pulses for the write cycle only
    assign arm_pulse = wr_mode & hwdata_i[`TSL_MODE_ARM_BIT]; // R04

    // register writes
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            mode_reg <= `TSL_RST_MODE;
            ramp_ofs_reg <= 16'h0000;
            phase_ofs_reg <= 32'h00000000;
            ramp_inc_reg <= `TSL_RST_RAMP_INC;
            phase_inc_reg <= `TSL_RST_PHASE_INC;
            ien_reg <= 2'h0;
        end
        else
        begin
            if (wr_mode)
                mode_reg <= {1'b0, hwdata_i[4:0]};
            if (wr_rofs)
                ramp_ofs_reg <= hwdata_i[15:0];
            if (wr_pofs)
                phase_ofs_reg <= hwdata_i;
            if (wr_rinc)
                ramp_inc_reg <= hwdata_i[15:0];
            if (wr_pinc)
                phase_inc_reg <= hwdata_i;
            if (wr_ien)
                ien_reg <= hwdata_i[1:0];
        end
    end

    // ---------------------------------------------------------------
    // trigger selection
    // ---------------------------------------------------------------
    logic trig;

    tsl_trig_edge u_trig
    (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .ev_valid_i(ev_tvalid_i),
        .ev_bits_i(ev_tdata_i[3:0]),
        .src_i(load_src),
        .trig_o(trig)
    );

    // ---------------------------------------------------------------
    // load-control state machine
    // ---------------------------------------------------------------
    tsl_state_e state_reg;
    tsl_state_e state_next;
    logic load_now;

    // next state and load strobe
    always_comb
    begin
        state_next = state_reg;
        load_now = 1'b0;
        unique case (state_reg)
            TSL_WAIT_ARM:
            begin
                if (arm_pulse)
                    state_next = TSL_ARMED; // R04
            end
            TSL_ARMED:
            begin
                if (trig)
                begin
                    load_now = 1'b1; // R05
                    if (!hold_armed)
                        state_next = TSL_WAIT_ARM; // R05
                end
                // hold-armed keeps the machine here
                if (hold_armed)
                    state_next = TSL_ARMED; // R02
            end
        endcase
    end

    // state register
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            state_reg <= TSL_WAIT_ARM; // R06
        else
            state_reg <= state_next;
    end

    // ---------------------------------------------------------------
    // ramp counter and phase accumulator
    // ---------------------------------------------------------------
    logic [15:0] ramp_reg;
    logic [31:0] phase_reg;
    wire advance = ~smp_tvalid_o | smp_tready_i;

    // offsets load on the load strobe, else step while stream moves
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            ramp_reg <= 16'h0000;
            phase_reg <= 32'h00000000;
        end
        else if (load_now)
        begin
            ramp_reg <= ramp_ofs_reg; // R05
            phase_reg <= phase_ofs_reg; // R05
        end
        else if (advance)
        begin
            ramp_reg <= ramp_reg + ramp_inc_reg;
            phase_reg <= phase_reg + phase_inc_reg;
        end
    end

    // parabolic sine approximation from phase
    logic [14:0] ph_frac;
    logic [29:0] ph_prod;
    logic [15:0] sine_mag;
    logic [15:0] sine_val;
    assign ph_frac = phase_reg[30:16];
    assign ph_prod = {15'h0000, ph_frac} * {15'h0000, ~ph_frac};
    assign sine_mag = {1'b0, ph_prod[29:15]};
    assign sine_val = phase_reg[31] ? (16'h0000 - sine_mag) : sine_mag;

    // ---------------------------------------------------------------
    // output stream
    // ---------------------------------------------------------------
    logic [15:0] smp_next;
    assign smp_next = sel_sine ? sine_val : ramp_reg; // R03

    // output sample register
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            smp_tdata_o <= 16'h0000;
            smp_tvalid_o <= 1'b0;
        end
        else if (advance)
        begin
            smp_tdata_o <= smp_next; // R03
            smp_tvalid_o <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    tsl_irq_t src_now;
    tsl_irq_t src_prev_reg;
    tsl_irq_t src_rise;
    tsl_irq_t flag_reg;
    tsl_irq_t flag_next;
    logic pulse_reg;

    assign src_now[`TSL_IRQ_ARMED] = (state_reg == TSL_ARMED);
    assign src_now[`TSL_IRQ_LOAD] = load_now;
    assign src_rise = src_now & ~src_prev_reg;
    // set beats write-one clear
    assign flag_next = (flag_reg & ~(wr_flag ? hwdata_i[1:0] : 2'h0)) | src_rise; // R08
    assign irq_o = |(flag_reg & ien_reg);
    assign irq_pulse_o = pulse_reg;

    // source history, flags, edge pulse
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            src_prev_reg <= 2'h0;
            flag_reg <= 2'h0;
            pulse_reg <= 1'b0;
        end
        else
        begin
            src_prev_reg <= src_now;
            flag_reg <= flag_next; // R08
            pulse_reg <= |(src_rise & ien_reg); // R07
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always_comb
    begin
        unique case (haddr_i)
            `TSL_OFF_MODE: rdata_next = {26'h0000000, mode_reg};
            `TSL_OFF_RAMP_OFS: rdata_next = {16'h0000, ramp_ofs_reg};
            `TSL_OFF_PHASE_OFS: rdata_next = phase_ofs_reg;
            `TSL_OFF_RAMP_INC: rdata_next = {16'h0000, ramp_inc_reg};
            `TSL_OFF_PHASE_INC: rdata_next = phase_inc_reg;
            `TSL_OFF_IRQ_STAT: rdata_next = {30'h00000000, src_now};
            `TSL_OFF_IRQ_EN: rdata_next = {30'h00000000, ien_reg};
            `TSL_OFF_IRQ_FLAG: rdata_next = {30'h00000000, flag_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end

    // read data stands through the data phase
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            rdata_reg <= 32'h00000000;
        else if (addr_ph & ~hwrite_i)
            rdata_reg <= rdata_next;
    end

endmodule : tsl_load_ctrl

//--- dv/tsl_load_ctrl_props.sv
`timescale 1ns/1ps
module tsl_load_ctrl_props
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic [15:0] smp_tdata_o,
    input wire logic smp_tvalid_o,
    input wire logic smp_tready_i,
    input wire logic irq_o,
    input wire logic irq_pulse_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ------------------------------
    // reset, stream and read data
    // ------------------------------
    a_rst_quiet: assert property ($rose(rst_n_i) |-> !smp_tvalid_o && !irq_o)
        else $error("outputs not cleared by reset");
    a_tvalid_on: assert property (rst_n_i && $past(rst_n_i) |-> smp_tvalid_o)
        else $error("sample valid dropped");
    a_stall_hold: assert property (smp_tvalid_o && !smp_tready_i |=> $stable(smp_tdata_o))
        else $error("sample moved while stalled");
    a_rd_stands: assert property ($past(rst_n_i) && !$past(hsel_i && htrans_i[1] && !hwrite_i)
        |-> $stable(hrdata_o)) else $error("read data changed without read");
    // ------------------------------
    // interrupts
    // ------------------------------
    a_pulse_irq: assert property (irq_pulse_o |-> irq_o)
        else $error("pulse without enabled flag");
    a_pulse_rst: assert property (irq_pulse_o |-> $past(rst_n_i))
        else $error("pulse right after reset");
    a_irq_fall: assert property ($fell(irq_o) && $past(rst_n_i)
        |-> $past(hsel_i && htrans_i[1] && hwrite_i, 2)) else $error("irq fell without write");
    a_irq_rise: assert property ($rose(irq_o) && $past(rst_n_i)
        |-> irq_pulse_o || $past(hsel_i && htrans_i[1] && hwrite_i, 2))
        else $error("irq rose without cause");
    c_pulse: cover property (irq_pulse_o);
    c_stall: cover property (smp_tvalid_o && !smp_tready_i);
    c_clear: cover property ($fell(irq_o));
endmodule : tsl_load_ctrl_props

bind tsl_load_ctrl tsl_load_ctrl_props i_props (.core_clk_i, .rst_n_i, .hsel_i, .htrans_i,
    .hwrite_i, .hready_i, .hrdata_o, .smp_tdata_o, .smp_tvalid_o, .smp_tready_i, .irq_o,
    .irq_pulse_o);

//--- dv/tsl_ev_src.sv
`timescale 1ns/1ps
module tsl_ev_src
(
    input wire logic core_clk_i,
    input wire logic stall_i,
    output logic ev_tvalid_o = 1'b0,
    output logic [7:0] ev_tdata_o = 8'hA5,
    output logic smp_tready_o
);
    // consumer ready, low while stalled
    assign smp_tready_o = !stall_i;
    // one valid beat, then idle bus shows the inverse
    task beat(input logic [7:0] b);
        ev_tvalid_o <= 1'b1;
        ev_tdata_o <= b;
        @(posedge core_clk_i);
        ev_tvalid_o <= 1'b0;
        ev_tdata_o <= ~b;
        @(posedge core_clk_i);
    endtask : beat
endmodule : tsl_ev_src

//--- dv/tb_tsl_load_ctrl.sv
`timescale 1ns/1ps
module tb_tsl_load_ctrl;
    import tsl_pkg::*;
    logic core_clk_i = 0;
    logic rst_n_i = 0;
    logic hsel_i = 0, hwrite_i = 0, stall = 0;
    logic [2:0] hsize_i = 3'h0;
    logic [7:0] haddr_i = 8'h00;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] hwdata_i = 32'h0, hrdata_o, rd;
    logic hready_i, hreadyout_o, hresp_o, ev_tvalid_i, smp_tvalid_o, smp_tready_i;
    logic irq_o, irq_pulse_o;
    logic [7:0] ev_tdata_i;
    logic [15:0] smp_tdata_o, s0;
    int err_total = 0, num_checks = 0, cyc = 0;
    // single slave drives bus ready
    assign hready_i = hreadyout_o;
    tsl_load_ctrl i_dut
    (
        .core_clk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i,
        .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .ev_tvalid_i, .ev_tdata_i,
        .smp_tdata_o, .smp_tvalid_o, .smp_tready_i, .irq_o, .irq_pulse_o
    );
    tsl_ev_src i_src
    (
        .core_clk_i, .stall_i(stall), .ev_tvalid_o(ev_tvalid_i), .ev_tdata_o(ev_tdata_i),
        .smp_tready_o(smp_tready_i)
    );
    // ------------------------------
    // clock, timeout, helpers
    // ------------------------------
    initial
    begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            wrap_up();
        end
    end
    task wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    // single word transfer, read data lands in rd
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        hsize_i <= 3'h2;
        do @(posedge core_clk_i); while (hready_i !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge core_clk_i); while (hready_i !== 1'b1);
        rd = hrdata_o;
    endtask : bus
    task do_reset();
        rst_n_i <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        @(posedge core_clk_i);
    endtask : do_reset
    // ------------------------------
    // scenarios
    // ------------------------------
    task t_reset();
        logic [7:0] offs [6] = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h40};
        logic [31:0] vals [6] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 6; i++)
        begin
            bus(0, offs[i], 0);
            chk("reset value", rd, vals[i]);
        end
        chk("bus answer", {hreadyout_o, hresp_o}, 32'h2);
    endtask : t_reset
    task t_edges();
        logic [2:0] code [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
        int bitn [6] = '{0, 1, 1, 2, 2, 3};
        logic [7:0] post;
        bus(1, 8'h18, 32'h3);
        for (int i = 0; i < 6; i++)
        begin
            post = 8'h01 << bitn[i];
            if (code[i] == 3'h3 || code[i] == 3'h5)
                post = ~post;
            bus(1, 8'h00, {27'h1, 2'h0, code[i]});
            i_src.beat(~post);
            i_src.beat(~post);
            bus(0, 8'h14, 0);
            chk("armed", rd, 32'h1);
            i_src.beat(post);
            bus(0, 8'h14, 0);
            chk("back to wait", rd, 32'h0);
            chk("irq level", irq_o, 1);
            bus(0, 8'h1C, 0);
            chk("flags", rd, 32'h3);
            bus(1, 8'h1C, 32'h3);
            bus(0, 8'h1C, 0);
            chk("flags cleared", rd, 32'h0);
        end
    endtask : t_edges
    task t_none();
        bus(1, 8'h00, 32'h26);
        i_src.beat(8'h00);
        i_src.beat(8'hFF);
        i_src.beat(8'h00);
        bus(0, 8'h14, 0);
        chk("code 110 armed", rd, 32'h1);
        do_reset();
        bus(0, 8'h14, 0);
        chk("state after reset", rd, 32'h0);
    endtask : t_none
    task t_hold();
        int pulses;
        pulses = 0;
        bus(1, 8'h18, 32'h2);
        bus(1, 8'h00, 32'h28);
        repeat (20)
        begin
            @(negedge core_clk_i);
            if (irq_pulse_o === 1'b1)
                pulses++;
        end
        @(posedge core_clk_i);
        chk("pulse count", pulses, 1);
        bus(0, 8'h14, 0);
        chk("held armed", rd[0], 1);
        bus(1, 8'h18, 32'h0);
        bus(0, 8'h1C, 0);
        chk("flag unmasked", rd[1], 1);
        @(negedge core_clk_i);
        chk("irq masked", irq_o, 0);
        do_reset();
        bus(1, 8'h00, 32'h2A);
        repeat (2)
        begin
            bus(1, 8'h1C, 32'h3);
            i_src.beat(8'h00);
            i_src.beat(8'h02);
            bus(0, 8'h1C, 0);
            chk("repeat load", rd[1], 1);
        end
        bus(0, 8'h14, 0);
        chk("still armed", rd[0], 1);
        do_reset();
    endtask : t_hold
    task t_ramp();
        bus(1, 8'h04, 32'h0100);
        bus(1, 8'h0C, 32'h3);
        bus(1, 8'h00, 32'h20);
        for (int i = 0; i < 10 && smp_tdata_o !== 16'h0100; i++)
            @(negedge core_clk_i);
        chk("immediate load", smp_tdata_o, 16'h0100);
        @(negedge core_clk_i);
        chk("ramp step", smp_tdata_o, 16'h0103);
        @(posedge core_clk_i);
        stall <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        stall <= 1'b0;
        @(negedge core_clk_i);
        chk("stalled ramp", smp_tdata_o, 16'h0106);
        @(posedge core_clk_i);
        bus(1, 8'h00, 32'h10);
        repeat (2) @(negedge core_clk_i);
        s0 = smp_tdata_o;
        @(negedge core_clk_i);
        chk("sine still", smp_tdata_o - s0, 16'h0);
    endtask : t_ramp
    initial
    begin
        do_reset();
        t_reset();
        t_edges();
        t_none();
        t_hold();
        t_ramp();
        wrap_up();
    end
endmodule : tb_tsl_load_ctrl
